// *** eig_defs.vh ***
`ifndef EIG_DEFS_VH
`define EIG_DEFS_VH
// Register word indices on the plain register port
`define EIG_REG_CTRL 4'h0
`define EIG_REG_STATUS 4'h1
`define EIG_REG_SLOT 4'h2
`define EIG_REG_REASON 4'h3
`define EIG_REG_PTR_BASE 4'h8
// Pointer word slots, low word first
`define EIG_PTR_THREAD 3'h0
`define EIG_PTR_EXIT 3'h2
`define EIG_PTR_URSP 3'h4
`define EIG_PTR_URBP 3'h6
// Control bit positions
`define EIG_CTRL_ENCLAVE 0
`define EIG_CTRL_GEN2 1
`define EIG_CTRL_TSD 2
`define EIG_CTRL_TSC_EXIT 3
`define EIG_CTRL_RAND_EXIT 4
`define EIG_CTRL_PAUSE_EXIT 5
`define EIG_CTRL_PLOOP_EXIT 6
`define EIG_CTRL_PRM_ACTIVE 7
`define EIG_CTRL_W 8
`define EIG_CTRL_RESET 8'h00
// Instruction classes
`define EIG_CLS_W 5
`define EIG_CLS_NORMAL 5'h00
`define EIG_CLS_IDENTIFY 5'h01
`define EIG_CLS_SECURE 5'h02
`define EIG_CLS_PERFCTR 5'h03
`define EIG_CLS_DTSTORE 5'h04
`define EIG_CLS_HVCALL 5'h05
`define EIG_CLS_VMFUNC 5'h06
`define EIG_CLS_PORTIO 5'h07
`define EIG_CLS_FARXFER 5'h08
`define EIG_CLS_SWINT 5'h09
`define EIG_CLS_IRET 5'h0a
`define EIG_CLS_SEGLOAD 5'h0b
`define EIG_CLS_SYSENTRY 5'h0c
`define EIG_CLS_MSW 5'h0d
`define EIG_CLS_ENTRY 5'h0e
`define EIG_CLS_RESUME 5'h0f
`define EIG_CLS_TSC 5'h10
`define EIG_CLS_RAND 5'h11
`define EIG_CLS_PAUSE 5'h12
`define EIG_CLS_STEP_TRAP 5'h13
`define EIG_CLS_BRK_TRAP 5'h14
`define EIG_CLS_CACHE_INV 5'h15
// Exit causes in the low half of the exit reason
`define EIG_CAUSE_W 3
`define EIG_CAUSE_NONE 3'h0
`define EIG_CAUSE_TSC 3'h1
`define EIG_CAUSE_RAND 3'h2
`define EIG_CAUSE_PAUSE 3'h3
`define EIG_CAUSE_PLOOP 3'h4
`define EIG_REASON_ENCLAVE_BIT 27
// Synthetic state
`define EIG_RESUME_LEAF 64'h0000000000000003
`define EIG_FLAGS_CLR_MASK 64'h00000000000108d5
`define EIG_GP_CODE_ZERO 16'h0000
// Exit stack choice
`define EIG_STK_APP 2'h0
`define EIG_STK_RING 2'h1
`define EIG_STK_TABLE 2'h2
`endif

// *** eig_decode.v ***
`timescale 1ns/10ps
`include "eig_defs.vh"
module eig_decode (
    input wire [4:0] cls_i,
    input wire [7:0] ctrl_i,
    input wire [1:0] current_priv_level_i,
    input wire ploop_hit_i,
    output reg ud_o,
    output reg gp_o,
    output reg vmexit_o,
    output reg [2:0] cause_o
);
    wire enc = ctrl_i[`EIG_CTRL_ENCLAVE];
    wire tsd_block = ctrl_i[`EIG_CTRL_TSD] && (current_priv_level_i != 2'h0);
    always @* begin
        ud_o = 1'b0;
        gp_o = 1'b0;
        vmexit_o = 1'b0;
        cause_o = `EIG_CAUSE_NONE;
        case (cls_i)
            `EIG_CLS_IDENTIFY, `EIG_CLS_SECURE, `EIG_CLS_PERFCTR, `EIG_CLS_DTSTORE, `EIG_CLS_HVCALL,
            `EIG_CLS_VMFUNC: begin
                ud_o = enc;
            end
            `EIG_CLS_PORTIO: begin
                ud_o = enc;
            end
            `EIG_CLS_FARXFER, `EIG_CLS_SWINT, `EIG_CLS_IRET, `EIG_CLS_SEGLOAD, `EIG_CLS_SYSENTRY: begin
                ud_o = enc;
            end
            `EIG_CLS_MSW: begin
                ud_o = enc;
            end
            `EIG_CLS_ENTRY, `EIG_CLS_RESUME: begin
                gp_o = enc;
            end
            `EIG_CLS_TSC: begin
                if (enc && !ctrl_i[`EIG_CTRL_GEN2]) begin
                    ud_o = 1'b1;
                end else if (tsd_block) begin
                    gp_o = 1'b1;
                end else if (ctrl_i[`EIG_CTRL_TSC_EXIT]) begin
                    vmexit_o = 1'b1;
                    cause_o = `EIG_CAUSE_TSC;
                end
            end
            `EIG_CLS_RAND: begin
                if (ctrl_i[`EIG_CTRL_RAND_EXIT]) begin
                    vmexit_o = 1'b1;
                    cause_o = `EIG_CAUSE_RAND;
                end
            end
            `EIG_CLS_PAUSE: begin
                if (ctrl_i[`EIG_CTRL_PAUSE_EXIT]) begin
                    vmexit_o = 1'b1;
                    cause_o = `EIG_CAUSE_PAUSE;
                end else if (ctrl_i[`EIG_CTRL_PLOOP_EXIT] && ploop_hit_i && current_priv_level_i == 2'h0 && !enc) begin
                    vmexit_o = 1'b1;
                    cause_o = `EIG_CAUSE_PLOOP;
                end
            end
            `EIG_CLS_CACHE_INV: begin
                gp_o = ctrl_i[`EIG_CTRL_PRM_ACTIVE];
            end
            default: begin
                ud_o = 1'b0;
            end
        endcase
    end
endmodule // eig_decode

// *** eig_top.v ***
// Summary of operation
// - In enclave, identify, secure-mode, perf-read, table-store, hypervisor calls fault invalid-opcode.
// - In enclave, all port input and output instructions fault invalid-opcode.
// - In enclave, far transfers, soft interrupts, segment loads, fast syscalls fault invalid-opcode.
// - Storing the machine status word in enclave faults invalid-opcode.
// - Enclave entry or resume from inside an enclave faults general-protection.
// - Timestamp read works in enclave on second generation, gated by disable bit.
// - Timestamp read in enclave may still exit to the hypervisor.
// - Random and seed reads are legal; exit only when random exiting is set.
// - Any instruction-boundary exit in enclave sets bit 27 of the exit reason.
// - After a random exit the hypervisor may clear control and re-execute.
// - Spin-wait hint is legal; in enclave it exits only when pause exiting is set.
// - Pause-loop exiting is ignored above privilege 0, so never from an enclave.
// - Single-step and breakpoint trap instructions are legal in enclave.
// - With reserved memory protection active, cache invalidate faults general-protection zero.
// - Interrupts, NMI, SMI, exceptions and VM exits force out of enclave first.
// - Exit saves registers into enclave memory, then loads synthetic values.
// - Exit loads the instruction pointer with the asynchronous exit pointer.
// - Exit restores stack and frame pointers to their pre-entry values.
// - Exit stack is new ring, current application, or interrupt stack table choice.
// - Exit puts resume leaf, control struct pointer and exit pointer in registers.
// - Exit clears carry, parity, aux, zero, sign, overflow, resume flags only.
// - Exit stack frame matches the same event outside enclave mode.
// - The resume leaf index written to the accumulator is 3.
// - Exit saves into the frame at the current slot, then increments the slot.
// - Exit zeroes data and index registers; upper eight zeroed only in 64-bit mode.
`timescale 1ns/10ps
`include "eig_defs.vh"
module eig_top #(
    parameter XLEN = 64
) (
    input wire core_clk_i,
    input wire rst_n_i,
    input wire [3:0] reg_addr_i,
    input wire [31:0] reg_wdata_i,
    input wire reg_we_i,
    input wire reg_re_i,
    output wire [31:0] reg_rdata_o,
    input wire insn_valid_i,
    input wire [4:0] insn_cls_i,
    input wire [1:0] current_priv_level_i,
    input wire ploop_hit_i,
    output wire insn_ready_o,
    output wire verdict_valid_o,
    output wire retire_o,
    output wire ud_o,
    output wire gp_o,
    output wire [15:0] gp_code_o,
    output wire vmexit_o,
    output wire [31:0] exit_reason_o,
    input wire enclave_exiting_event_i,
    input wire priv_change_i,
    input wire interrupt_stack_table_i,
    input wire mode64_i,
    input wire [XLEN-1:0] flags_i,
    output wire save_req_o,
    output wire [31:0] save_slot_o,
    input wire save_ack_i,
    output wire load_o,
    output wire [XLEN-1:0] rax_o,
    output wire [XLEN-1:0] rbx_o,
    output wire [XLEN-1:0] rcx_o,
    output wire [XLEN-1:0] rdx_o,
    output wire [XLEN-1:0] rsi_o,
    output wire [XLEN-1:0] rdi_o,
    output wire [XLEN-1:0] rsp_o,
    output wire [XLEN-1:0] rbp_o,
    output wire [XLEN-1:0] rip_o,
    output wire [XLEN-1:0] rflags_o,
    output wire upper_zero_o,
    output wire push_req_o,
    output wire [1:0] stack_sel_o,
    input wire push_ack_i,
    output wire enclave_o
);
    localparam ST_IDLE = 4'b0001;
    localparam ST_SAVE = 4'b0010;
    localparam ST_LOAD = 4'b0100;
    localparam ST_PUSH = 4'b1000;

    reg [3:0] state_r;
    reg [3:0] state_nxt;
    reg [7:0] ctrl_r;
    reg [31:0] save_slot_r;
    reg [31:0] ptr_r [0:7];
    reg [31:0] rdata_r;
    reg [31:0] reason_r;
    reg verdict_r;
    reg retire_r;
    reg ud_r;
    reg gp_r;
    reg vmexit_r;
    reg save_req_r;
    reg load_r;
    reg push_req_r;
    reg [1:0] stack_sel_r;
    reg [XLEN-1:0] flags_cap_r;
    reg mode64_r;
    reg [XLEN-1:0] rax_r;
    reg [XLEN-1:0] rbx_r;
    reg [XLEN-1:0] rcx_r;
    reg [XLEN-1:0] rdx_r;
    reg [XLEN-1:0] rsi_r;
    reg [XLEN-1:0] rdi_r;
    reg [XLEN-1:0] rsp_r;
    reg [XLEN-1:0] rbp_r;
    reg [XLEN-1:0] rip_r;
    reg [XLEN-1:0] rflags_r;
    reg upper_zero_r;

    wire dec_ud;
    wire dec_gp;
    wire dec_vmexit;
    wire [2:0] dec_cause;
    wire idle = state_r[0];
    wire take_insn = insn_valid_i && idle;
    wire in_enclave = ctrl_r[`EIG_CTRL_ENCLAVE];
    wire insn_eee = take_insn && in_enclave && (dec_ud || dec_gp || dec_vmexit);
    // Faults and exits on instructions are themselves exiting events
    wire async_enclave_exit = idle && in_enclave && (enclave_exiting_event_i || insn_eee);
    wire wr_ptr = reg_we_i && reg_addr_i[3];
    wire [XLEN-1:0] mode_mask = mode64_r ? {XLEN{1'b1}} : {{(XLEN-32){1'b0}}, 32'hffffffff};
    wire [XLEN-1:0] thread_ctl_ptr = {ptr_r[`EIG_PTR_THREAD+3'h1], ptr_r[`EIG_PTR_THREAD]};
    wire [XLEN-1:0] async_exit_ptr = {ptr_r[`EIG_PTR_EXIT+3'h1], ptr_r[`EIG_PTR_EXIT]};
    wire [XLEN-1:0] ursp = {ptr_r[`EIG_PTR_URSP+3'h1], ptr_r[`EIG_PTR_URSP]};
    wire [XLEN-1:0] urbp = {ptr_r[`EIG_PTR_URBP+3'h1], ptr_r[`EIG_PTR_URBP]};
    wire [31:0] status_w = {22'h000000, stack_sel_r, state_r, 3'h0, in_enclave};

    eig_decode u_dec (
        .cls_i(insn_cls_i),
        .ctrl_i(ctrl_r),
        .current_priv_level_i(current_priv_level_i),
        .ploop_hit_i(ploop_hit_i),
        .ud_o(dec_ud),
        .gp_o(dec_gp),
        .vmexit_o(dec_vmexit),
        .cause_o(dec_cause)
    );

    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (async_enclave_exit) begin
                    state_nxt = ST_SAVE;
                end
            end
            ST_SAVE: begin
                if (save_ack_i) begin
                    state_nxt = ST_LOAD;
                end
            end
            ST_LOAD: begin
                state_nxt = ST_PUSH;
            end
            ST_PUSH: begin
                if (push_ack_i) begin
                    state_nxt = ST_IDLE;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    always @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            state_r <= ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Verdict stage: only a clean instruction retires, so a fault never leaves state behind
    always @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            verdict_r <= 1'b0;
            retire_r <= 1'b0;
            ud_r <= 1'b0;
            gp_r <= 1'b0;
            vmexit_r <= 1'b0;
            reason_r <= 32'h00000000;
        end else begin
            verdict_r <= take_insn;
            retire_r <= take_insn && !dec_ud && !dec_gp && !dec_vmexit;
            ud_r <= take_insn && dec_ud;
            gp_r <= take_insn && dec_gp;
            vmexit_r <= take_insn && !dec_ud && !dec_gp && dec_vmexit;
            if (take_insn && !dec_ud && !dec_gp && dec_vmexit) begin
                reason_r <= 32'h00000000;
                reason_r[`EIG_REASON_ENCLAVE_BIT] <= in_enclave;
                reason_r[2:0] <= dec_cause;
            end
        end
    end

    // Control and pointer registers
    always @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            ctrl_r <= `EIG_CTRL_RESET;
            save_slot_r <= 32'h00000000;
        end else begin
            if (reg_we_i && reg_addr_i == `EIG_REG_CTRL) begin
                ctrl_r <= reg_wdata_i[`EIG_CTRL_W-1:0];
            end
            // The exit wins over a software write in the same cycle
            if (state_r[2]) begin
                ctrl_r[`EIG_CTRL_ENCLAVE] <= 1'b0;
            end
            if (state_r[2]) begin
                save_slot_r <= save_slot_r + 32'h00000001;
            end else if (reg_we_i && reg_addr_i == `EIG_REG_SLOT) begin
                save_slot_r <= reg_wdata_i;
            end
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < 8; gi = gi + 1) begin : g_ptr
            always @(posedge core_clk_i) begin
                if (!rst_n_i) begin
                    ptr_r[gi] <= 32'h00000000;
                end else if (wr_ptr && {29'h00000000, reg_addr_i[2:0]} == gi) begin
                    ptr_r[gi] <= reg_wdata_i;
                end
            end
        end
    endgenerate

    // Read data valid only in the cycle after the strobe
    always @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            rdata_r <= 32'h00000000;
        end else if (reg_re_i) begin
            if (reg_addr_i[3]) begin
                rdata_r <= ptr_r[reg_addr_i[2:0]];
            end else begin
                case (reg_addr_i)
                    `EIG_REG_CTRL: rdata_r <= {24'h000000, ctrl_r};
                    `EIG_REG_STATUS: rdata_r <= status_w;
                    `EIG_REG_SLOT: rdata_r <= save_slot_r;
                    `EIG_REG_REASON: rdata_r <= reason_r;
                    default: rdata_r <= 32'h00000000;
                endcase
            end
        end else begin
            rdata_r <= 32'h00000000;
        end
    end

    // Asynchronous exit sequence
    always @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            save_req_r <= 1'b0;
            load_r <= 1'b0;
            push_req_r <= 1'b0;
            stack_sel_r <= `EIG_STK_APP;
            flags_cap_r <= {XLEN{1'b0}};
            mode64_r <= 1'b0;
        end else begin
            load_r <= 1'b0;
            if (async_enclave_exit) begin
                save_req_r <= 1'b1;
                flags_cap_r <= flags_i;
                mode64_r <= mode64_i;
                if (interrupt_stack_table_i) begin
                    stack_sel_r <= `EIG_STK_TABLE;
                end else if (priv_change_i) begin
                    stack_sel_r <= `EIG_STK_RING;
                end else begin
                    stack_sel_r <= `EIG_STK_APP;
                end
            end
            if (state_r[1] && save_ack_i) begin
                save_req_r <= 1'b0;
                load_r <= 1'b1;
            end
            if (state_r[2]) begin
                push_req_r <= 1'b1;
            end
            if (state_r[3] && push_ack_i) begin
                push_req_r <= 1'b0;
            end
        end
    end

    // Synthetic register image, loaded only after the save has been acknowledged
    always @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            rax_r <= {XLEN{1'b0}};
            rbx_r <= {XLEN{1'b0}};
            rcx_r <= {XLEN{1'b0}};
            rdx_r <= {XLEN{1'b0}};
            rsi_r <= {XLEN{1'b0}};
            rdi_r <= {XLEN{1'b0}};
            rsp_r <= {XLEN{1'b0}};
            rbp_r <= {XLEN{1'b0}};
            rip_r <= {XLEN{1'b0}};
            rflags_r <= {XLEN{1'b0}};
            upper_zero_r <= 1'b0;
        end else if (state_r[1] && save_ack_i) begin
            rax_r <= `EIG_RESUME_LEAF;
            rbx_r <= thread_ctl_ptr & mode_mask;
            rcx_r <= async_exit_ptr & mode_mask;
            rdx_r <= {XLEN{1'b0}};
            rsi_r <= {XLEN{1'b0}};
            rdi_r <= {XLEN{1'b0}};
            rsp_r <= ursp & mode_mask;
            rbp_r <= urbp & mode_mask;
            rip_r <= async_exit_ptr & mode_mask;
            rflags_r <= flags_cap_r & ~`EIG_FLAGS_CLR_MASK;
            upper_zero_r <= mode64_r;
        end
    end

    assign reg_rdata_o = rdata_r;
    assign insn_ready_o = state_r[0];
    assign verdict_valid_o = verdict_r;
    assign retire_o = retire_r;
    assign ud_o = ud_r;
    assign gp_o = gp_r;
    assign gp_code_o = `EIG_GP_CODE_ZERO;
    assign vmexit_o = vmexit_r;
    assign exit_reason_o = reason_r;
    assign save_req_o = save_req_r;
    assign save_slot_o = save_slot_r;
    assign load_o = load_r;
    assign rax_o = rax_r;
    assign rbx_o = rbx_r;
    assign rcx_o = rcx_r;
    assign rdx_o = rdx_r;
    assign rsi_o = rsi_r;
    assign rdi_o = rdi_r;
    assign rsp_o = rsp_r;
    assign rbp_o = rbp_r;
    assign rip_o = rip_r;
    assign rflags_o = rflags_r;
    assign upper_zero_o = upper_zero_r;
    assign push_req_o = push_req_r;
    assign stack_sel_o = stack_sel_r;
    assign enclave_o = ctrl_r[`EIG_CTRL_ENCLAVE];
endmodule // eig_top

// *** eig_top_assertions.sv ***
`timescale 1ns/10ps
`include "eig_defs.vh"
module eig_top_checker #(
    parameter XLEN = 64
) (
    input wire core_clk_i,
    input wire rst_n_i,
    input wire insn_valid_i,
    input wire [4:0] insn_cls_i,
    input wire insn_ready_o,
    input wire retire_o,
    input wire ud_o,
    input wire gp_o,
    input wire [15:0] gp_code_o,
    input wire vmexit_o,
    input wire [31:0] exit_reason_o,
    input wire enclave_exiting_event_i,
    input wire save_req_o,
    input wire save_ack_i,
    input wire [31:0] save_slot_o,
    input wire load_o,
    input wire [XLEN-1:0] rax_o,
    input wire [XLEN-1:0] rcx_o,
    input wire [XLEN-1:0] rdx_o,
    input wire [XLEN-1:0] rip_o,
    input wire push_req_o,
    input wire enclave_o
);
    // Only instructions the core really took while in enclave mode are judged
    wire acc = insn_valid_i && insn_ready_o && enclave_o;
    wire [4:0] k = insn_cls_i;
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!rst_n_i);

    a_ident_ud: assert property (acc && k >= `EIG_CLS_IDENTIFY && k <= `EIG_CLS_VMFUNC
        |=> ud_o && !vmexit_o) else $error("identify class did not fault");
    a_portio_ud: assert property (acc && k == `EIG_CLS_PORTIO |=> ud_o && !gp_o)
        else $error("port access did not fault");
    a_priv_ud: assert property (acc && k >= `EIG_CLS_FARXFER && k <= `EIG_CLS_SYSENTRY |=> ud_o)
        else $error("privilege class did not fault");
    a_msw_ud: assert property (acc && k == `EIG_CLS_MSW |=> ud_o)
        else $error("status word store did not fault");
    a_reentry_gp: assert property (acc && (k == `EIG_CLS_ENTRY || k == `EIG_CLS_RESUME)
        |=> gp_o && !ud_o) else $error("re-entry did not give protection fault");
    a_rand_legal: assert property (acc && k == `EIG_CLS_RAND
        |=> !ud_o && !gp_o && (retire_o || vmexit_o)) else $error("random read refused");
    a_trap_legal: assert property (acc && (k == `EIG_CLS_STEP_TRAP || k == `EIG_CLS_BRK_TRAP)
        |=> retire_o) else $error("trap instruction refused");
    a_encl_reason: assert property (vmexit_o && $past(acc) |-> ##[0:1] exit_reason_o[27])
        else $error("enclave exit reason bit missing");
    a_no_ploop: assert property (vmexit_o && $past(acc)
        |-> ##[0:1] exit_reason_o[2:0] != `EIG_CAUSE_PLOOP) else $error("pause-loop exit from enclave");
    a_gp_code: assert property (gp_o |-> gp_code_o == 16'h0000)
        else $error("protection fault code not zero");
    a_fault_clean: assert property ((ud_o || gp_o) |-> !retire_o && !vmexit_o)
        else $error("fault with retire or exit");
    a_event_exit: assert property (enclave_exiting_event_i && insn_ready_o && enclave_o
        |=> save_req_o && enclave_o) else $error("event did not start exit");
    a_save_first: assert property (load_o |-> $past(save_req_o) && $past(save_ack_i))
        else $error("load before save finished");
    a_synth_regs: assert property (load_o |-> rax_o == 3 && rcx_o == rip_o && rdx_o == 0)
        else $error("synthetic registers wrong");
    a_slot_step: assert property (load_o
        |=> save_slot_o == $past(save_slot_o) + 1 && !enclave_o && push_req_o) else $error("slot not stepped");
endmodule // eig_top_checker

bind eig_top eig_top_checker #(.XLEN(XLEN)) u_eig_chk (.core_clk_i, .rst_n_i, .insn_valid_i, .insn_cls_i,
    .insn_ready_o, .retire_o, .ud_o, .gp_o, .gp_code_o, .vmexit_o, .exit_reason_o, .enclave_exiting_event_i,
    .save_req_o, .save_ack_i, .save_slot_o, .load_o, .rax_o, .rcx_o, .rdx_o, .rip_o, .push_req_o, .enclave_o);

// *** eig_tb.sv ***
`timescale 1ns/10ps
`include "eig_defs.vh"
module tb;
    logic core_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [3:0] reg_addr_i = 4'h0;
    logic [31:0] reg_wdata_i = 32'h0;
    logic reg_we_i = 1'b0, reg_re_i = 1'b0, insn_valid_i = 1'b0, ploop_hit_i = 1'b0;
    logic enclave_exiting_event_i = 1'b0, priv_change_i = 1'b0, interrupt_stack_table_i = 1'b0, mode64_i = 1'b1;
    logic save_ack_i = 1'b0, push_ack_i = 1'b0;
    logic [4:0] insn_cls_i = 5'h00;
    logic [1:0] current_priv_level_i = 2'h3;
    logic [63:0] flags_i = 64'hfedc_ba98_7654_3210;
    wire [31:0] reg_rdata_o, save_slot_o, exit_reason_o;
    wire [15:0] gp_code_o;
    wire [1:0] stack_sel_o;
    wire [63:0] rax_o, rbx_o, rcx_o, rdx_o, rsi_o, rdi_o, rsp_o, rbp_o, rip_o, rflags_o;
    wire insn_ready_o, verdict_valid_o, retire_o, ud_o, gp_o, vmexit_o, save_req_o, load_o, upper_zero_o;
    wire push_req_o, enclave_o;
    int n_mismatch = 0;
    int compares = 0;
    logic [31:0] slot = 32'h0;
    localparam logic [3:0] R = 4'h8, U = 4'h4, G = 4'h2, V = 4'h1;

    eig_top #(.XLEN(64)) DUT (.core_clk_i, .rst_n_i, .reg_addr_i, .reg_wdata_i, .reg_we_i, .reg_re_i,
        .reg_rdata_o, .insn_valid_i, .insn_cls_i, .current_priv_level_i, .ploop_hit_i, .insn_ready_o,
        .verdict_valid_o, .retire_o, .ud_o, .gp_o, .gp_code_o, .vmexit_o, .exit_reason_o,
        .enclave_exiting_event_i, .priv_change_i, .interrupt_stack_table_i, .mode64_i, .flags_i,
        .save_req_o, .save_slot_o, .save_ack_i, .load_o, .rax_o, .rbx_o,
        .rcx_o, .rdx_o, .rsi_o, .rdi_o, .rsp_o, .rbp_o, .rip_o, .rflags_o, .upper_zero_o, .push_req_o,
        .stack_sel_o, .push_ack_i, .enclave_o);

    always #2 core_clk_i = ~core_clk_i;

    // Memory side answers one cycle late so the request must hold across an idle edge
    always @(posedge core_clk_i) begin
        save_ack_i <= save_req_o & ~save_ack_i;
        push_ack_i <= push_req_o & ~push_ack_i;
    end

    function automatic logic [31:0] pw(input int k);
        pw = {k[7:0], 24'h5a3c96};
    endfunction

    function automatic logic [63:0] ptr(input int k);
        ptr = {pw(k + 1), pw(k)};
    endfunction

    task automatic chk(input logic [63:0] g, input logic [63:0] e, input string m);
        compares++;
        if (g !== e) begin
            n_mismatch++;
            $display("mismatch at %0t: %s got %h expected %h", $time, m, g, e);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge core_clk_i);
        reg_we_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge core_clk_i);
        reg_we_i <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, input logic [31:0] e, input string m);
        @(posedge core_clk_i);
        reg_re_i <= 1'b1;
        reg_addr_i <= a;
        @(posedge core_clk_i);
        reg_re_i <= 1'b0;
        #1 chk(reg_rdata_o, e, m);
    endtask

    task automatic ins(input logic [4:0] k, input logic [3:0] r);
        @(posedge core_clk_i);
        insn_valid_i <= 1'b1;
        insn_cls_i <= k;
        @(posedge core_clk_i);
        insn_valid_i <= 1'b0;
        #1 chk({verdict_valid_o, retire_o, ud_o, gp_o, vmexit_o}, {1'b1, r}, "verdict");
        if (r == G) chk(gp_code_o, 16'h0000, "gp code");
    endtask

    // Follows one exit from save request to idle; 32-bit mode sees only low words
    task automatic exit_seq();
        logic [63:0] mk;
        int i;
        mk = mode64_i ? 64'hffff_ffff_ffff_ffff : 64'h0000_0000_ffff_ffff;
        for (i = 0; i < 40 && save_req_o !== 1'b1; i++) @(posedge core_clk_i) #1;
        chk(save_slot_o, slot, "save slot");
        for (i = 0; i < 40 && load_o !== 1'b1; i++) @(posedge core_clk_i) #1;
        chk(load_o, 1'b1, "load");
        chk(rax_o, 64'h3, "leaf");
        chk(rbx_o, ptr(8) & mk, "thread ptr");
        chk(rcx_o, ptr(10) & mk, "count reg");
        chk(rip_o, ptr(10) & mk, "ip");
        chk(rdx_o | rsi_o | rdi_o, 64'h0, "zeroed");
        chk(upper_zero_o, mode64_i, "upper");
        chk(rsp_o, ptr(12) & mk, "sp");
        chk(rbp_o, ptr(14) & mk, "fp");
        chk(rflags_o, flags_i & ~64'h108d5, "flags");
        for (i = 0; i < 40 && push_req_o !== 1'b1; i++) @(posedge core_clk_i) #1;
        chk(stack_sel_o, interrupt_stack_table_i ? 2'h2 : {1'b0, priv_change_i}, "stack");
        chk(enclave_o, 1'b0, "left enclave");
        slot = slot + 32'h1;
        chk(save_slot_o, slot, "slot step");
        for (i = 0; i < 40 && insn_ready_o !== 1'b1; i++) @(posedge core_clk_i) #1;
    endtask

    task automatic step(input logic [7:0] c, input logic [4:0] k, input logic [3:0] r, input logic [2:0] ca);
        wr(4'h0, {24'h0, c});
        ins(k, r);
        if (c[0] && r != R) exit_seq();
        if (r == V) chk(exit_reason_o, {4'h0, c[0], 24'h0, ca}, "reason");
    endtask

    task automatic t_regs();
        int k;
        rd(4'h0, 32'h0, "ctrl reset");
        rd(4'h1, 32'h10, "status reset");
        rd(4'h2, 32'h0, "slot reset");
        wr(4'h1, 32'hffff_ffff);
        wr(4'h5, 32'hffff_ffff);
        rd(4'h1, 32'h10, "status read only");
        rd(4'h5, 32'h0, "unmapped");
        for (k = 8; k < 16; k++) wr(k[3:0], pw(k));
        rd(4'hd, pw(13), "pointer");
        wr(4'h0, 32'hff);
        rd(4'h0, 32'hff, "ctrl");
    endtask

    // Every exit control set; none applies to these classes, so a missing fault would show as a retire
    task automatic t_illegal();
        int k;
        for (k = 1; k < 16; k++) begin
            {mode64_i, interrupt_stack_table_i, priv_change_i} <= k[2:0];
            flags_i <= flags_i + 64'h0123;
            step(8'h79, k[4:0], k > 13 ? G : U, 3'h0);
        end
    endtask

    task automatic t_timer();
        step(8'h03, `EIG_CLS_TSC, R, 3'h0);
        step(8'h01, `EIG_CLS_TSC, U, 3'h0);
        step(8'h07, `EIG_CLS_TSC, G, 3'h0);
        step(8'h0b, `EIG_CLS_TSC, V, 3'h1);
    endtask

    task automatic t_rand_pause();
        ploop_hit_i <= 1'b1;
        step(8'h11, `EIG_CLS_RAND, V, 3'h2);
        step(8'h01, `EIG_CLS_RAND, R, 3'h0);
        step(8'h21, `EIG_CLS_PAUSE, V, 3'h3);
        step(8'h01, `EIG_CLS_PAUSE, R, 3'h0);
        step(8'h41, `EIG_CLS_PAUSE, R, 3'h0);
        step(8'h01, `EIG_CLS_STEP_TRAP, R, 3'h0);
        step(8'h01, `EIG_CLS_BRK_TRAP, R, 3'h0);
        step(8'h81, `EIG_CLS_CACHE_INV, G, 3'h0);
        step(8'h01, `EIG_CLS_NORMAL, R, 3'h0);
    endtask

    task automatic t_outside();
        current_priv_level_i <= 2'h0;
        step(8'h40, `EIG_CLS_PAUSE, V, 3'h4);
        step(8'h80, `EIG_CLS_CACHE_INV, G, 3'h0);
        step(8'h00, `EIG_CLS_IDENTIFY, R, 3'h0);
        current_priv_level_i <= 2'h3;
    endtask

    task automatic t_event();
        wr(4'h0, 32'h0);
        priv_change_i <= 1'b1;
        interrupt_stack_table_i <= 1'b0;
        @(posedge core_clk_i) enclave_exiting_event_i <= 1'b1;
        @(posedge core_clk_i) enclave_exiting_event_i <= 1'b0;
        repeat (3) @(posedge core_clk_i);
        #1 chk({save_req_o, insn_ready_o}, 2'b01, "ignored outside");
        wr(4'h0, 32'h1);
        @(posedge core_clk_i) enclave_exiting_event_i <= 1'b1;
        @(posedge core_clk_i) enclave_exiting_event_i <= 1'b0;
        // Step off the launching edge before looking at the request
        #1 exit_seq();
        rd(4'h2, slot, "slot count");
    endtask

    task automatic stop_test();
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    initial begin
        repeat (10) @(posedge core_clk_i);
        rst_n_i <= 1'b1;
        t_regs();
        t_illegal();
        t_timer();
        t_rand_pause();
        t_outside();
        t_event();
        stop_test();
    end

    // Whole run needs a few hundred cycles; this leaves a wide margin
    initial begin
        #40000;
        n_mismatch++;
        stop_test();
    end
endmodule // tb
